//--- inc/batt_meas_pkg.sv
package batt_meas_pkg;
   // Clock and timing
   localparam int CLK_HZ = 25000000;
   localparam real CURR_PERIOD_MS = 27.46;
   localparam int CURR_PERIOD_CYC = int'(CURR_PERIOD_MS * CLK_HZ / 1000.0);
   // Register indices as seen by the command port
   localparam logic [1:0] REG_TEMP = 2'h0;
   localparam logic [1:0] REG_VOLT = 2'h1;
   localparam logic [1:0] REG_CURR = 2'h2;
   localparam logic [1:0] REG_OFFS = 2'h3;
   // Field layout
   localparam int TEMP_LSB = 3;
   localparam int VOLT_BITS = 10;
   localparam int OFFS_LSB = 3;
   localparam int OFFS_MAG = 9;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [7:0] ZERO8 = 8'h00;

   // Voltage conversion sequence
   typedef enum logic [1:0] {V_IDLE, V_WAIT, V_STORE} vstate_t;

   // Register read/write request from the bus engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] sel;
      logic hiByte;
      logic [7:0] data;
   } regReq_t;

   // Analog converter results
   typedef struct packed {
      logic valid;
      logic [15:0] value;
   } convRes_t;
endpackage

//--- verilog/battery_measurement_result_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Temperature is 13-bit two's complement in bits 15:3; bits 2:0 read zero.
// - Serial bytes travel LSB first; the byte-wide port here feeds that shifter.
// - A 10-bit voltage conversion runs only on a host convert command.
// - A finished voltage conversion lands in the two-byte voltage result register.
// - Voltage is unsigned, 10 mV per step, ten bits across low byte and two high.
// - Configuration selects supply or auxiliary input for each voltage conversion.
// - Current conversions start on their own every 27.46 ms.
// - Current conversions run only while current_conv_enable is one.
// - Current result is 16-bit two's complement, 0.2441 mV per step.
// - Current result MSB is the sign: charge positive, discharge negative.
// - Offset register is added to each raw current before storing.
// - Offset is a two-byte two's complement host read/write, writable only while current conversions are off; every reset reloads it from OFFS_INIT.
// - Offset bits 2:0 zero, 11:3 magnitude, 12 sign, 15:13 copy the sign.
module battery_measurement_result_regs
   import batt_meas_pkg::*;
#(
   parameter int CURR_PERIOD = CURR_PERIOD_CYC,
   parameter logic [15:0] OFFS_INIT = 16'h0000
)(
   input wire logic clk,
   input wire logic rstn,
   input wire regReq_t regReq,
   input wire logic convVoltCmd,
   input wire logic currConvEnable,
   input wire logic selAuxInput,
   input wire convRes_t tempRes,
   input wire convRes_t voltSupplyRes,
   input wire convRes_t voltAuxRes,
   input wire convRes_t currRawRes,
   output logic [7:0] readData,
   output logic readValid,
   output logic voltStart,
   output logic voltSelAux,
   output logic currStart,
   output logic voltBusy,
   output logic offsWriteRefused
);
   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] volt;
      logic [15:0] curr;
      logic [15:0] offs;
      vstate_t vState;
      logic vSelAux;
      logic [31:0] tick;
      logic [7:0] readData;
      logic readValid;
      logic voltStart;
      logic currStart;
      logic refused;
      logic busy;
   } state_t;

   state_t st, next_st;
   logic [1:0] rstSync;
   logic rstIntN;
   // Combinational helpers
   logic [15:0] rdWord;
   logic [15:0] offsIn;
   convRes_t vRes;
   logic tickDone;
   logic [15:0] currSum;

   // Reset release through two flops
   // Entry into reset is immediate, exit waits two edges so every flop leaves it together
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstIntN = rstSync[1];

   // Read word for the selected register
   // REG_OFFS, the one code left, takes the default arm and reads the offset register
   always_comb begin
      case (regReq.sel)
         REG_TEMP: rdWord = st.temp;
         REG_VOLT: rdWord = st.volt;
         REG_CURR: rdWord = st.curr;
         default: rdWord = st.offs;
      endcase
   end

   // Offset byte formatting: sign copied over the top three bits, low three forced zero
   // Whatever the host writes, the stored word stays a legal offset
   always_comb begin
      offsIn = st.offs;
      if (regReq.hiByte) begin
         offsIn[15:8] = {{3{regReq.data[4]}}, regReq.data[4:0]};
      end else begin
         offsIn[7:0] = {regReq.data[7:OFFS_LSB], 3'h0};
      end
   end

   // Voltage result from the input chosen when the command was taken
   assign vRes = st.vSelAux ? voltAuxRes : voltSupplyRes;

   // Last cycle of a current conversion period
   assign tickDone = (st.tick >= 32'(CURR_PERIOD - 1));

   // Raw current plus offset; the 16-bit sum wraps like the register does
   // Sign stays in bit 15 as long as raw reading plus offset fits in 16 bits
   assign currSum = currRawRes.value + st.offs;

   // Next state
   // Pulses default low so each stands for exactly one cycle
   always_comb begin
      next_st = st;
      next_st.readValid = 1'b0;
      next_st.voltStart = 1'b0;
      next_st.currStart = 1'b0;
      next_st.refused = 1'b0;
      // Temperature result, low bits masked
      // Junk from the converter in the low bits never reaches the host
      if (tempRes.valid) begin
         next_st.temp = {tempRes.value[15:TEMP_LSB], 3'h0};
      end
      // Register reads, a byte at a time for the LSB-first shifter
      // The byte stands until the next read
      if (regReq.rd) begin
         next_st.readData = regReq.hiByte ? rdWord[15:8] : rdWord[7:0];
         next_st.readValid = 1'b1;
      end
      // Offset writes, refused while current conversions are enabled
      // The refusal pulse tells the host its write was lost
      if (regReq.wr && regReq.sel == REG_OFFS) begin
         if (currConvEnable) begin
            next_st.refused = 1'b1;
         end else begin
            next_st.offs = offsIn;
         end
      end
      // Voltage conversion on command only
      // A command that arrives while a conversion runs is dropped
      case (st.vState)
         V_IDLE: begin
            if (convVoltCmd) begin
               next_st.vSelAux = selAuxInput;
               next_st.voltStart = 1'b1;
               next_st.vState = V_WAIT;
            end
         end
         V_WAIT: begin
            if (vRes.valid) begin
               next_st.volt = {6'h00, vRes.value[VOLT_BITS-1:0]};
               next_st.vState = V_IDLE;
            end
         end
         default: next_st.vState = V_IDLE;
      endcase

      // Busy follows the state the voltage sequencer moves to
      next_st.busy = (next_st.vState == V_WAIT);
      // Background current timer
      // Clearing the enable restarts the period, so the first start comes a full period later
      if (!currConvEnable) begin
         next_st.tick = 32'h0;
      end else if (tickDone) begin
         next_st.tick = 32'h0;
         next_st.currStart = 1'b1;
      end else begin
         next_st.tick = st.tick + 32'h1;
      end
      // Offset-corrected current, signed wrap keeps sign in MSB
      // Results that arrive after the enable drops are thrown away
      if (currRawRes.valid && currConvEnable) begin
         next_st.curr = currSum;
      end
   end

   // State register; the offset reloads OFFS_INIT on reset, standing in for its nonvolatile image
   // A pack that needs another power-up offset sets OFFS_INIT to its calibrated value
   always_ff @(posedge clk or negedge rstIntN) begin
      if (!rstIntN) begin
         st.temp <= ZERO16;
         st.volt <= ZERO16;
         st.curr <= ZERO16;
         st.vState <= V_IDLE;
         st.vSelAux <= 1'b0;
         st.tick <= 32'h0;
         st.readData <= ZERO8;
         st.readValid <= 1'b0;
         st.voltStart <= 1'b0;
         st.currStart <= 1'b0;
         st.refused <= 1'b0;
         st.offs <= OFFS_INIT;
         st.busy <= 1'b0;
      end else begin
         st.temp <= next_st.temp;
         st.volt <= next_st.volt;
         st.curr <= next_st.curr;
         st.vState <= next_st.vState;
         st.vSelAux <= next_st.vSelAux;
         st.tick <= next_st.tick;
         st.readData <= next_st.readData;
         st.readValid <= next_st.readValid;
         st.voltStart <= next_st.voltStart;
         st.currStart <= next_st.currStart;
         st.refused <= next_st.refused;
         st.offs <= next_st.offs;
         st.busy <= next_st.busy;
      end
   end

   // Outputs from flops
   // Busy has its own flop so no output passes through decode logic
   assign readData = st.readData;
   assign readValid = st.readValid;
   assign voltStart = st.voltStart;
   assign voltSelAux = st.vSelAux;
   assign currStart = st.currStart;
   assign voltBusy = st.busy;
   assign offsWriteRefused = st.refused;
endmodule

//--- dv/batt_meas_checker.sv
`timescale 1ns/10ps
module batt_meas_checker
   import batt_meas_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire regReq_t regReq,
   input wire logic convVoltCmd,
   input wire logic currConvEnable,
   input wire logic selAuxInput,
   input wire logic [7:0] readData,
   input wire logic readValid,
   input wire logic voltStart,
   input wire logic voltSelAux,
   input wire logic currStart,
   input wire logic voltBusy,
   input wire logic offsWriteRefused
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Accepted command and converter launch
   sequence cmdTaken; convVoltCmd && !voltBusy; endsequence
   sequence launch; voltStart && voltBusy; endsequence
   a_volt_cmd_start: assert property (cmdTaken |=> launch) else $error("no launch");
   a_volt_cmd_only: assert property (voltStart |-> $past(convVoltCmd)) else $error("stray launch");
   a_volt_input_sel: assert property (cmdTaken |=> voltSelAux == $past(selAuxInput)) else $error("input");
   a_curr_when_on: assert property (currStart |-> $past(currConvEnable)) else $error("curr off");
   a_curr_spacing: assert property (currStart |=> !currStart [*8]) else $error("curr rate");
   a_read_reply: assert property (readValid == $past(regReq.rd)) else $error("reply");
   a_volt_high_zero: assert property (readValid && $past(regReq.sel) == REG_VOLT && $past(regReq.hiByte)
      |-> readData[7:2] == 6'h00) else $error("volt high");
   a_temp_low_zero: assert property (readValid && $past(regReq.sel) == REG_TEMP && !$past(regReq.hiByte)
      |-> readData[2:0] == 3'h0) else $error("temp low");
   a_offs_refused: assert property (regReq.wr && regReq.sel == REG_OFFS && currConvEnable
      |=> offsWriteRefused) else $error("refusal");
endmodule
bind battery_measurement_result_regs batt_meas_checker u_batt_meas_checker (.*);

//--- dv/meas_front_end_model.sv
`timescale 1ns/10ps
module meas_front_end_model
   import batt_meas_pkg::*;
#(parameter int DLY = 5)(
   input wire logic clk,
   input wire logic voltStart,
   input wire logic voltSelAux,
   input wire logic currStart,
   input wire logic [15:0] supCode,
   input wire logic [15:0] auxCode,
   input wire logic [15:0] currCode,
   output convRes_t voltSupplyRes = '0,
   output convRes_t voltAuxRes = '0,
   output convRes_t currRawRes = '0
);
   int cnt = 0;
   // One conversion per launch on the chosen input; values scramble when not valid
   always @(posedge clk) begin
      cnt <= voltStart ? DLY : (cnt > 0 ? cnt - 1 : 0);
      voltSupplyRes <= (cnt == 1 && !voltSelAux) ? {1'b1, supCode} : {1'b0, ~voltSupplyRes.value};
      voltAuxRes <= (cnt == 1 && voltSelAux) ? {1'b1, auxCode} : {1'b0, ~voltAuxRes.value};
      currRawRes <= currStart ? {1'b1, currCode} : {1'b0, ~currRawRes.value};
   end
endmodule

//--- dv/battery_measurement_result_regs_test.sv
`timescale 1ns/10ps
module battery_measurement_result_regs_test;
   import batt_meas_pkg::*;
   // Rows: input select, converter code, expected register word
   localparam logic [32:0] ROWS [5] = '{{1'b0, 16'h0005, 16'h0005}, {1'b1, 16'h03E8, 16'h03E8},
      {1'b0, 16'hFFFF, 16'h03FF}, {1'b1, 16'hFD0E, 16'h010E}, {1'b0, 16'hFD68, 16'h0168}};
   logic clk = 1'b0, rstn = 1'b0, cmd = 1'b0, en = 1'b0, aux = 1'b0;
   regReq_t req = '0;
   convRes_t tempRes = '0;
   convRes_t vs, va, cr;
   logic [15:0] sup = 16'h0000, auxc = 16'h0000, curr = 16'h0000;
   logic [7:0] rd, q;
   logic rv, vStart, vSel, cStart, busy, refused;
   int err_count = 0, compares = 0, cycles = 0;
   always #20 clk = ~clk;
   battery_measurement_result_regs #(.CURR_PERIOD(20)) u_battery_measurement_result_regs (.clk(clk), .rstn(rstn),
      .regReq(req), .convVoltCmd(cmd), .currConvEnable(en), .selAuxInput(aux), .tempRes(tempRes),
      .voltSupplyRes(vs), .voltAuxRes(va), .currRawRes(cr), .readData(rd), .readValid(rv), .voltStart(vStart),
      .voltSelAux(vSel), .currStart(cStart), .voltBusy(busy), .offsWriteRefused(refused));
   meas_front_end_model u_meas_front_end_model (.clk(clk), .voltStart(vStart), .voltSelAux(vSel),
      .currStart(cStart), .supCode(sup), .auxCode(auxc), .currCode(curr), .voltSupplyRes(vs),
      .voltAuxRes(va), .currRawRes(cr));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One byte access from a clock edge; reply or refusal checked at the falling edge after the taking edge
   task automatic acc(input logic w, input logic [1:0] sel, input logic hi, input logic [7:0] d);
      req <= '{w, !w, sel, hi, d};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      q = rd;
      chk({7'h0, w ? refused : rv}, {7'h0, w ? en : 1'b1});
      @(posedge clk);
   endtask
   // Low byte then high byte
   task automatic rdchk(input logic [1:0] sel, input logic [15:0] exp);
      acc(1'b0, sel, 1'b0, 8'h00);
      chk(q, exp[7:0]);
      acc(1'b0, sel, 1'b1, 8'h00);
      chk(q, exp[15:8]);
   endtask
   // Host calibration: zero offset, read the zero-current reading, store its negation
   task automatic calib(input logic [15:0] raw);
      logic [15:0] neg;
      neg = -raw;
      en <= 1'b0;
      curr <= raw;
      acc(1'b1, REG_OFFS, 1'b0, 8'h00);
      acc(1'b1, REG_OFFS, 1'b1, 8'h00);
      en <= 1'b1;
      repeat (30) @(posedge clk);
      rdchk(REG_CURR, raw);
      en <= 1'b0;
      acc(1'b1, REG_OFFS, 1'b0, neg[7:0]);
      acc(1'b1, REG_OFFS, 1'b1, neg[15:8]);
      rdchk(REG_OFFS, neg);
      en <= 1'b1;
      repeat (30) @(posedge clk);
      rdchk(REG_CURR, 16'h0000);
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         test_done();
      end
   end
   initial begin
      repeat (19) @(posedge clk);
      @(negedge clk);
      chk({rv, vStart, cStart, busy, refused, vSel, 2'h0}, 8'h00);
      chk(rd, 8'h00);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      $display("reset test done");
      foreach (ROWS[i]) begin
         aux <= ROWS[i][32];
         sup <= ROWS[i][32] ? 16'h0155 : ROWS[i][31:16];
         auxc <= ROWS[i][32] ? ROWS[i][31:16] : 16'h02AA;
         cmd <= 1'b1;
         @(posedge clk);
         cmd <= 1'b0;
         @(negedge clk);
         chk({5'h0, vSel, vStart, busy}, {5'h0, ROWS[i][32], 2'h3});
         @(posedge clk);
         cmd <= 1'b1;
         @(posedge clk);
         cmd <= 1'b0;
         @(negedge clk);
         chk({5'h0, vSel, vStart, busy}, {5'h0, ROWS[i][32], 2'h1});
         for (int k = 0; k < 50 && busy !== 1'b0; k++) @(negedge clk);
         @(posedge clk);
         rdchk(REG_VOLT, ROWS[i][15:0]);
         $display("voltage row %0d done", i);
      end
      tempRes <= '{1'b1, 16'hE6F7};
      @(posedge clk);
      tempRes <= '{1'b0, 16'h1918};
      rdchk(REG_TEMP, 16'hE6F0);
      $display("temperature test done");
      acc(1'b1, REG_OFFS, 1'b0, 8'hFF);
      acc(1'b1, REG_OFFS, 1'b1, 8'h10);
      rdchk(REG_OFFS, 16'hF0F8);
      acc(1'b1, REG_OFFS, 1'b1, 8'hEF);
      rdchk(REG_OFFS, 16'h0FF8);
      calib(16'h0028);
      calib(16'hFFF0);
      acc(1'b1, REG_OFFS, 1'b0, 8'h00);
      rdchk(REG_OFFS, 16'h0010);
      curr <= 16'hFF00;
      repeat (30) @(posedge clk);
      rdchk(REG_CURR, 16'hFF10);
      en <= 1'b0;
      curr <= 16'h0100;
      repeat (30) @(posedge clk);
      rdchk(REG_CURR, 16'hFF10);
      $display("offset and current test done");
      test_done();
   end
endmodule
